// *** design/pmcs_pkg.sv ***
/*
  constants, register map, reset values and state codes for the power
  control and start-up sequencer.
  assumes a 10 MHz pclk; the 32 kHz timing ticks and the switching
  phase pulse are all derived from it as one-cycle enables.
*/
// Overview of operation
// - request high, supply good: turn on, flag
// - turn-on event moves off mode to sequencing
// - host reset is open-drain, active low
// - release host reset 2.0 ms after last enable
// - host reset reasserted only on turn-off
// - reset release purely timer based
// - unmasked fault pulls interrupt pin low
// - interrupt holds until software writes one
// - select high: card regulator lower range
// - select low: card regulator higher range
// - invalid io supply forces select high
// - fixed slots 1..5 or off, step selectable
// - sequence timing from trimmed 32 kHz tick
// - untrimmed tick on low supply or all-pfm
// - accurate timing uses divided trimmed clock
// - on-mode debounce uses trimmed derived tick
// - request and low-input debounce use untrimmed
// - switching phase derived from trimmed clock
package pmcs_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_HZ = 32_768;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int UNTRIM_DIV = CLK_HZ / TICK_HZ;
  localparam int SW_HZ = 2_000_000;
  localparam int SW_DIV = CLK_HZ / SW_HZ;
  localparam int STEP_LONG_US = 2000;
  localparam int STEP_SHORT_US = 500;
  localparam int RST_DELAY_US = 2000;
  localparam int DEBOUNCE_US = 122;
  localparam int STEP_LONG_TICKS = (STEP_LONG_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int STEP_SHORT_TICKS = (STEP_SHORT_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int RST_DELAY_TICKS = (RST_DELAY_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int DEBOUNCE_TICKS = (DEBOUNCE_US * TICK_HZ) / 1_000_000;
  localparam int NREG = 9;
  localparam int NFAULT = 4;
  localparam int SLOT_W = 3;
  localparam logic [2:0] MAX_SLOT = 3'h5;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SEQ = 8'h04;
  localparam logic [7:0] OFF_PFM = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_ENABLES = 8'h18;
  // reset values: slots sw1,sw2,sw3,ldo1..4,v33,card from index 0 upward
  localparam logic [26:0] SEQ_RST =
    {3'h4, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h2, 3'h1};
  localparam logic [0:0] CTRL_RST = 1'h0;
  localparam logic [8:0] PFM_RST = 9'h000;
  localparam logic [5:0] MASK_RST = 6'h00;
  // flag bit positions
  localparam int FLG_TURN_ON = 0;
  localparam int FLG_LOW_IN = 1;
  localparam int FLG_FAULT0 = 2;
  // status bit positions
  localparam int ST_SENSE = 0;
  localparam int ST_LOW_IN = 1;
  localparam int ST_UNTRIM = 2;
  localparam int ST_CARD_LOW = 3;
  localparam int ST_RST_PIN = 4;
  localparam int ST_IRQ_PIN = 5;
  localparam int ST_STATE = 6;
  typedef enum logic [3:0] {
    PMCS_OFF = 4'b0001,
    PMCS_SEQ = 4'b0010,
    PMCS_RST = 4'b0100,
    PMCS_ON = 4'b1000
  } pmcs_state_t;
endpackage

// *** design/pmcs_core.sv ***
/*
  power control and start-up sequencer with an apb register slave.
  assumes pclk at 10 MHz, asynchronous active-low presetn, and that all
  pin inputs are asynchronous; open-drain pins are split into in/out/oe.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module pmcs_core #(
  parameter int NREG = pmcs_pkg::NREG,
  parameter int NFAULT = pmcs_pkg::NFAULT,
  parameter int TICK_DIV = pmcs_pkg::TICK_DIV,
  parameter int UNTRIM_DIV = pmcs_pkg::UNTRIM_DIV,
  parameter int SW_DIV = pmcs_pkg::SW_DIV
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped
  input wire logic turn_on_request, // turn-on request pin
  input wire logic vin_above_input_undervoltage_threshold, // supply above threshold
  input wire logic card_rail_select, // card range select pin
  input wire logic io_supply_ok, // io supply valid
  input wire logic [NFAULT-1:0] fault_in, // fault detector levels
  input wire logic host_reset_out_n_i, // reset pin level
  output logic host_reset_out_n_o, // reset pin drive value
  output logic host_reset_out_n_oe, // reset pin pulled low
  input wire logic fault_irq_out_n_i, // irq pin level
  output logic fault_irq_out_n_o, // irq pin drive value
  output logic fault_irq_out_n_oe, // irq pin pulled low
  output logic [NREG-1:0] reg_enable, // regulator enables
  output logic card_low_range, // card regulator lower range
  output logic osc_untrimmed_sel, // untrimmed oscillator in use
  output logic sw_phase_pulse // switching phase pulse
);
  localparam int NDEB = NFAULT + 2;
  localparam int NSYNC = NFAULT + 6;

  typedef logic [2:0] pmcs_slot_t;

  // slot of regulator i in a packed slot word
  function automatic pmcs_slot_t pmcs_slot_of(input logic [26:0] cfg, input int i);
    pmcs_slot_t s;
    s = cfg[i*3 +: 3];
    if (s > pmcs_pkg::MAX_SLOT) begin
      s = 3'h0;
    end
    return s;
  endfunction

  // highest slot used, zero when all are off
  function automatic pmcs_slot_t pmcs_last_slot(input logic [26:0] cfg);
    pmcs_slot_t m;
    m = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (pmcs_slot_of(cfg, i) > m) begin
        m = pmcs_slot_of(cfg, i);
      end
    end
    return m;
  endfunction

  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [15:0] tdiv_reg;
  logic [15:0] udiv_reg;
  logic [7:0] sdiv_reg;
  logic trim_tick_reg;
  logic raw_tick_reg;
  logic [NDEB-1:0] deb_reg;
  logic [NDEB-1:0] deb_d_reg;
  logic [2:0] deb_cnt_reg [NDEB];
  logic [0:0] ctrl_reg;
  logic [26:0] seq_reg;
  logic [26:0] seq_cfg_reg;
  logic [8:0] pfm_reg;
  logic [NDEB-1:0] flags_reg;
  logic [NDEB-1:0] mask_reg;
  pmcs_pkg::pmcs_state_t state_reg;
  pmcs_slot_t slot_reg;
  logic [7:0] tcnt_reg;
  logic [NREG-1:0] en_reg;
  logic prdy_reg;
  logic perr_reg;
  logic [31:0] rdata_reg;
  logic card_low_reg;
  logic untrim_reg;
  logic sw_pulse_reg;
  logic rst_oe_reg;
  logic irq_oe_reg;

  // named views of the synchronised pins
  logic s_on, s_vin, s_card, s_io, s_rst_pin, s_irq_pin;
  logic [NFAULT-1:0] s_fault;
  assign s_on = sync2_reg[0];
  assign s_vin = sync2_reg[1];
  assign s_card = sync2_reg[2];
  assign s_io = sync2_reg[3];
  assign s_rst_pin = sync2_reg[4];
  assign s_irq_pin = sync2_reg[5];
  assign s_fault = sync2_reg[NSYNC-1:6];

  // two-flop synchroniser for every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {fault_in, fault_irq_out_n_i, host_reset_out_n_i,
                    io_supply_ok, card_rail_select, vin_above_input_undervoltage_threshold, turn_on_request};
      sync2_reg <= sync1_reg;
    end
  end

  // untrimmed source selection
  logic untrim_next;
  assign untrim_next = !s_vin || (&pfm_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      untrim_reg <= 1'b1;
    end else begin
      untrim_reg <= untrim_next;
    end
  end

  // trimmed 32 kHz tick divided from the accurate clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_reg <= '0;
      trim_tick_reg <= 1'b0;
    end else if (tdiv_reg == 16'(TICK_DIV - 1)) begin
      tdiv_reg <= '0;
      trim_tick_reg <= 1'b1;
    end else begin
      tdiv_reg <= tdiv_reg + 16'h0001;
      trim_tick_reg <= 1'b0;
    end
  end

  // free-running untrimmed 32 kHz tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      udiv_reg <= '0;
      raw_tick_reg <= 1'b0;
    end else if (udiv_reg == 16'(UNTRIM_DIV - 1)) begin
      udiv_reg <= '0;
      raw_tick_reg <= 1'b1;
    end else begin
      udiv_reg <= udiv_reg + 16'h0001;
      raw_tick_reg <= 1'b0;
    end
  end

  // per-input debounce tick: request and low input always untrimmed
  logic [NDEB-1:0] deb_raw;
  logic [NDEB-1:0] deb_tick;
  logic fault_tick;
  assign fault_tick = (state_reg == pmcs_pkg::PMCS_ON && !untrim_reg) ?
                      trim_tick_reg : raw_tick_reg;
  assign deb_raw = {s_fault, !s_vin, s_on};
  assign deb_tick = {{NFAULT{fault_tick}}, raw_tick_reg, raw_tick_reg};

  // debounce filters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_reg <= '0;
      deb_d_reg <= '0;
      for (int i = 0; i < NDEB; i++) begin
        deb_cnt_reg[i] <= 3'h0;
      end
    end else begin
      deb_d_reg <= deb_reg;
      for (int i = 0; i < NDEB; i++) begin
        if (deb_raw[i] == deb_reg[i]) begin
          deb_cnt_reg[i] <= 3'h0;
        end else if (deb_tick[i]) begin
          if (deb_cnt_reg[i] == 3'(pmcs_pkg::DEBOUNCE_TICKS - 1)) begin
            deb_reg[i] <= deb_raw[i];
            deb_cnt_reg[i] <= 3'h0;
          end else begin
            deb_cnt_reg[i] <= deb_cnt_reg[i] + 3'h1;
          end
        end
      end
    end
  end

  // turn-on and turn-off events
  logic turn_on_evt, turn_off_evt;
  logic [7:0] step_len;
  pmcs_slot_t last_slot;
  assign turn_on_evt = state_reg == pmcs_pkg::PMCS_OFF && deb_reg[0] && s_vin;
  assign turn_off_evt = state_reg != pmcs_pkg::PMCS_OFF && (!deb_reg[0] || !s_vin);
  assign step_len = ctrl_reg[0] ? 8'(pmcs_pkg::STEP_SHORT_TICKS) :
                    8'(pmcs_pkg::STEP_LONG_TICKS);
  assign last_slot = pmcs_last_slot(seq_cfg_reg);

  // sequencer: slots, reset release delay, off on turn-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= pmcs_pkg::PMCS_OFF;
      slot_reg <= 3'h0;
      tcnt_reg <= 8'h00;
      seq_cfg_reg <= pmcs_pkg::SEQ_RST;
    end else if (turn_off_evt) begin
      state_reg <= pmcs_pkg::PMCS_OFF;
      slot_reg <= 3'h0;
      tcnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        pmcs_pkg::PMCS_OFF: begin
          if (turn_on_evt) begin
            state_reg <= pmcs_pkg::PMCS_SEQ;
            seq_cfg_reg <= seq_reg;
            slot_reg <= 3'h0;
            tcnt_reg <= 8'h00;
          end
        end
        pmcs_pkg::PMCS_SEQ: begin
          if (slot_reg >= last_slot) begin
            state_reg <= pmcs_pkg::PMCS_RST;
            tcnt_reg <= 8'h00;
          end else if (trim_tick_reg) begin
            if (tcnt_reg == step_len - 8'h01) begin
              tcnt_reg <= 8'h00;
              slot_reg <= slot_reg + 3'h1;
            end else begin
              tcnt_reg <= tcnt_reg + 8'h01;
            end
          end
        end
        pmcs_pkg::PMCS_RST: begin
          if (trim_tick_reg) begin
            if (tcnt_reg == 8'(pmcs_pkg::RST_DELAY_TICKS - 1)) begin
              state_reg <= pmcs_pkg::PMCS_ON;
            end else begin
              tcnt_reg <= tcnt_reg + 8'h01;
            end
          end
        end
        pmcs_pkg::PMCS_ON: begin
          state_reg <= pmcs_pkg::PMCS_ON;
        end
        default: begin
          state_reg <= pmcs_pkg::PMCS_OFF;
        end
      endcase
    end
  end

  // regulator enables by slot, off slots stay disabled
  logic [NREG-1:0] en_next;
  always_comb begin
    en_next = '0;
    for (int i = 0; i < NREG; i++) begin
      en_next[i] = state_reg != pmcs_pkg::PMCS_OFF && !turn_off_evt &&
                   pmcs_slot_of(seq_cfg_reg, i) != 3'h0 &&
                   pmcs_slot_of(seq_cfg_reg, i) <= slot_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= '0;
    end else begin
      en_reg <= en_next;
    end
  end

  // host reset pulled low outside on mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_oe_reg <= 1'b1;
    end else begin
      rst_oe_reg <= state_reg != pmcs_pkg::PMCS_ON || turn_off_evt;
    end
  end

  // card range, invalid io supply reads as high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_low_reg <= 1'b1;
    end else begin
      card_low_reg <= s_card || !s_io;
    end
  end

  // switching phase from the accurate clock while rails run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdiv_reg <= 8'h00;
      sw_pulse_reg <= 1'b0;
    end else if (en_reg == '0) begin
      sdiv_reg <= 8'h00;
      sw_pulse_reg <= 1'b0;
    end else if (sdiv_reg == 8'(SW_DIV - 1)) begin
      sdiv_reg <= 8'h00;
      sw_pulse_reg <= 1'b1;
    end else begin
      sdiv_reg <= sdiv_reg + 8'h01;
      sw_pulse_reg <= 1'b0;
    end
  end

  // apb decode
  logic setup_ph, wr_en;
  logic [NDEB-1:0] flag_set, flag_clr;
  assign setup_ph = psel && !penable;
  assign wr_en = psel && penable && prdy_reg && pwrite;
  assign flag_set = {deb_reg[NDEB-1:2] & ~deb_d_reg[NDEB-1:2],
                     deb_reg[1] & !deb_d_reg[1], turn_on_evt};
  assign flag_clr = (wr_en && paddr == pmcs_pkg::OFF_FLAGS) ?
                    pwdata[NDEB-1:0] : '0;

  // sticky flags: set beats a simultaneous write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end
  end

  // interrupt pin pulled low while any unmasked flag stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe_reg <= 1'b0;
    end else begin
      irq_oe_reg <= |(flags_reg & ~mask_reg);
    end
  end

  // writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= pmcs_pkg::CTRL_RST;
      seq_reg <= pmcs_pkg::SEQ_RST;
      pfm_reg <= pmcs_pkg::PFM_RST;
      mask_reg <= NDEB'(pmcs_pkg::MASK_RST);
    end else if (wr_en) begin
      case (paddr)
        pmcs_pkg::OFF_CTRL: ctrl_reg <= pwdata[0:0];
        pmcs_pkg::OFF_SEQ: seq_reg <= pwdata[26:0];
        pmcs_pkg::OFF_PFM: pfm_reg <= pwdata[8:0];
        pmcs_pkg::OFF_MASK: mask_reg <= pwdata[NDEB-1:0];
        default: begin
        end
      endcase
    end
  end

  // read mux
  logic [31:0] rd_val;
  logic rd_err;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      pmcs_pkg::OFF_CTRL: rd_val[0] = ctrl_reg[0];
      pmcs_pkg::OFF_SEQ: rd_val[26:0] = seq_reg;
      pmcs_pkg::OFF_PFM: rd_val[8:0] = pfm_reg;
      pmcs_pkg::OFF_FLAGS: rd_val[NDEB-1:0] = flags_reg;
      pmcs_pkg::OFF_MASK: rd_val[NDEB-1:0] = mask_reg;
      pmcs_pkg::OFF_STATUS: begin
        rd_val[pmcs_pkg::ST_SENSE] = deb_reg[0];
        rd_val[pmcs_pkg::ST_LOW_IN] = deb_reg[1];
        rd_val[pmcs_pkg::ST_UNTRIM] = untrim_reg;
        rd_val[pmcs_pkg::ST_CARD_LOW] = card_low_reg;
        rd_val[pmcs_pkg::ST_RST_PIN] = s_rst_pin;
        rd_val[pmcs_pkg::ST_IRQ_PIN] = s_irq_pin;
        rd_val[pmcs_pkg::ST_STATE +: 4] = state_reg;
      end
      pmcs_pkg::OFF_ENABLES: rd_val[NREG-1:0] = en_reg;
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer: captured in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdy_reg <= 1'b0;
      perr_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdy_reg <= 1'b1;
      perr_reg <= rd_err;
      rdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      prdy_reg <= 1'b0;
      perr_reg <= 1'b0;
    end
  end

  // outputs straight from flops; open drain only ever drives low
  assign prdata = rdata_reg;
  assign pready = prdy_reg;
  assign pslverr = perr_reg;
  assign host_reset_out_n_o = 1'b0;
  assign host_reset_out_n_oe = rst_oe_reg;
  assign fault_irq_out_n_o = 1'b0;
  assign fault_irq_out_n_oe = irq_oe_reg;
  assign reg_enable = en_reg;
  assign card_low_range = card_low_reg;
  assign osc_untrimmed_sel = untrim_reg;
  assign sw_phase_pulse = sw_pulse_reg;
endmodule

// *** bench/pmcs_core_asserts.sv ***
/*
  port checker for the power control and start-up sequencer core.
  assumes it is bound into pmcs_core, with pclk and async active-low presetn.
*/
`timescale 1ns/10ps
module pmcs_core_asserts #(
  parameter int NREG = 9,
  parameter int TICK_DIV = 4
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic card_rail_select, // range select pin
  input wire logic io_supply_ok, // io supply valid
  input wire logic vin_above_input_undervoltage_threshold, // supply good
  input wire logic host_reset_out_n_o, // reset drive value
  input wire logic host_reset_out_n_oe, // reset pulled low
  input wire logic fault_irq_out_n_o, // irq drive value
  input wire logic fault_irq_out_n_oe, // irq pulled low
  input wire logic [NREG-1:0] reg_enable, // regulator enables
  input wire logic card_low_range, // lower card range
  input wire logic osc_untrimmed_sel, // untrimmed oscillator
  input wire logic sw_phase_pulse // switching phase pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int REL_MIN = (pmcs_pkg::RST_DELAY_TICKS - 1) * TICK_DIV;
  localparam int REL_MAX = (pmcs_pkg::RST_DELAY_TICKS + 1) * TICK_DIV;
  logic irq_wr;
  logic [NREG-1:0] en_q;
  logic [15:0] quiet_cnt;
  // completing write that may lower the interrupt
  assign irq_wr = psel && penable && pready && pwrite &&
    (paddr == pmcs_pkg::OFF_FLAGS || paddr == pmcs_pkg::OFF_MASK);
  // cycles since the enable set last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
      quiet_cnt <= 16'h0000;
    end else begin
      en_q <= reg_enable;
      quiet_cnt <= (reg_enable != en_q) ? 16'h0000 : quiet_cnt + 16'h0001;
    end
  end
  sequence s_card_low;
    (card_rail_select || !io_supply_ok) [*5];
  endsequence
  sequence s_card_high;
    (!card_rail_select && io_supply_ok) [*5];
  endsequence
  sequence s_phase_run;
    sw_phase_pulse && reg_enable != '0 ##1 (reg_enable != '0) [*4];
  endsequence
  a_rst_open_drain: assert property (host_reset_out_n_o == 1'b0)
    else $error("reset pin driven high");
  a_irq_open_drain: assert property (fault_irq_out_n_o == 1'b0)
    else $error("irq pin driven high");
  a_rst_only_off: assert property ($rose(host_reset_out_n_oe) |-> ##[0:2] reg_enable == '0)
    else $error("reset reasserted with rails on");
  a_seq_order: assert property ((reg_enable != en_q && reg_enable != '0) |->
    ((en_q & ~reg_enable) == '0 && host_reset_out_n_oe))
    else $error("enable order or reset state wrong");
  a_rst_release: assert property ($fell(host_reset_out_n_oe) && reg_enable != '0 |->
    quiet_cnt >= REL_MIN && quiet_cnt <= REL_MAX)
    else $error("reset released at wrong delay");
  a_card_low: assert property (s_card_low |-> card_low_range)
    else $error("card range not low");
  a_card_high: assert property (s_card_high |-> !card_low_range)
    else $error("card range not high");
  a_osc_untrim: assert property (!vin_above_input_undervoltage_threshold [*5] |-> osc_untrimmed_sel)
    else $error("untrimmed oscillator not chosen");
  a_sw_phase: assert property (s_phase_run |=> sw_phase_pulse)
    else $error("switching phase pulse missing");
  a_irq_clear: assert property ($fell(fault_irq_out_n_oe) |->
    $past(irq_wr) || $past(irq_wr, 2) || $past(irq_wr, 3))
    else $error("irq released without clear");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing wrong");
endmodule
bind pmcs_core pmcs_core_asserts #(.NREG(NREG), .TICK_DIV(TICK_DIV)) u_pmcs_core_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .card_rail_select(card_rail_select),
  .io_supply_ok(io_supply_ok), .vin_above_input_undervoltage_threshold(vin_above_input_undervoltage_threshold),
  .host_reset_out_n_o(host_reset_out_n_o), .host_reset_out_n_oe(host_reset_out_n_oe),
  .fault_irq_out_n_o(fault_irq_out_n_o), .fault_irq_out_n_oe(fault_irq_out_n_oe),
  .reg_enable(reg_enable), .card_low_range(card_low_range),
  .osc_untrimmed_sel(osc_untrimmed_sel), .sw_phase_pulse(sw_phase_pulse)
);

// *** bench/pmcs_host_model.sv ***
/*
  host side model: pull-ups on the open-drain reset and irq lines and a
  count of reset releases the host sees.
  assumes the core only ever pulls the lines low through its enables.
*/
`timescale 1ns/10ps
module pmcs_host_model (
  input wire logic rst_o, // core reset drive value
  input wire logic rst_oe, // core pulls reset
  input wire logic irq_o, // core irq drive value
  input wire logic irq_oe, // core pulls irq
  output logic rst_n, // resolved reset line
  output logic irq_n, // resolved irq line
  output int releases // reset releases seen
);
  // released lines rest high on the host pull-ups
  assign rst_n = rst_oe ? rst_o : 1'b1;
  assign irq_n = irq_oe ? irq_o : 1'b1;
  // host leaves reset on each rising edge of the line
  initial releases = 0;
  always @(posedge rst_n) begin
    releases++;
  end
endmodule

// *** bench/tb_top.sv ***
/*
  self-checking bench for the power control and start-up sequencer.
  assumes pmcs_core with fast tick dividers and the host pull-up model.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int TD = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic turn_on_request, vin_above_input_undervoltage_threshold, card_rail_select, io_supply_ok;
  logic [3:0] fault_in;
  logic rst_n, irq_n, rst_o, rst_oe, irq_o, irq_oe;
  logic [8:0] reg_enable;
  logic card_low_range, osc_untrimmed_sel, sw_phase_pulse;
  logic [26:0] seq_cfg;
  int errors, checks_done, releases, cyc, smin, lastc, reft, np, d;
  int slot[9];
  int on_t[9];
  pmcs_core #(.TICK_DIV(TD), .UNTRIM_DIV(TD)) u_pmcs_core (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .turn_on_request(turn_on_request), .vin_above_input_undervoltage_threshold(vin_above_input_undervoltage_threshold),
    .card_rail_select(card_rail_select), .io_supply_ok(io_supply_ok), .fault_in(fault_in),
    .host_reset_out_n_i(rst_n), .host_reset_out_n_o(rst_o), .host_reset_out_n_oe(rst_oe),
    .fault_irq_out_n_i(irq_n), .fault_irq_out_n_o(irq_o), .fault_irq_out_n_oe(irq_oe),
    .reg_enable(reg_enable), .card_low_range(card_low_range),
    .osc_untrimmed_sel(osc_untrimmed_sel), .sw_phase_pulse(sw_phase_pulse)
  );
  pmcs_host_model u_pmcs_host_model (
    .rst_o(rst_o), .rst_oe(rst_oe), .irq_o(irq_o), .irq_oe(irq_oe),
    .rst_n(rst_n), .irq_n(irq_n), .releases(releases)
  );
  // compare helpers
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    if (n >= 16) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask
  // random slot table, turn-on, and timing of every enable and the release
  task automatic run_seq(input int k);
    int step;
    step = (k != 0 ? pmcs_pkg::STEP_SHORT_TICKS : pmcs_pkg::STEP_LONG_TICKS) * TD;
    smin = 9;
    lastc = 0;
    cyc = 0;
    for (int i = 0; i < 9; i++) begin
      slot[i] = (i == 0) ? $urandom_range(5, 1) : $urandom_range(5, 0);
      seq_cfg[3*i +: 3] = slot[i][2:0];
      on_t[i] = -1;
      if (slot[i] != 0 && slot[i] < smin) smin = slot[i];
    end
    apb(1'b1, pmcs_pkg::OFF_CTRL, 32'(k));
    apb(1'b1, pmcs_pkg::OFF_SEQ, {5'h00, seq_cfg});
    turn_on_request <= 1'b1;
    vin_above_input_undervoltage_threshold <= 1'b1;
    while (rst_n !== 1'b1 && cyc < 5000) begin
      @(posedge pclk);
      cyc++;
      for (int i = 0; i < 9; i++) if (reg_enable[i] === 1'b1 && on_t[i] < 0) on_t[i] = cyc;
    end
    for (int i = 0; i < 9; i++) if (slot[i] == smin) reft = on_t[i];
    for (int i = 0; i < 9; i++) begin
      if (slot[i] == 0) begin
        chk_bit(on_t[i] == -1, 1'b1);
      end else begin
        d = on_t[i] - reft - (slot[i] - smin) * step;
        chk_bit(d <= TD && d >= -TD, 1'b1);
        if (on_t[i] > lastc) lastc = on_t[i];
      end
    end
    d = cyc - lastc - pmcs_pkg::RST_DELAY_TICKS * TD;
    chk_bit(d <= TD && d >= -TD, 1'b1);
    chk_word(releases, 32'(k + 1));
    apb(1'b0, pmcs_pkg::OFF_STATUS, 32'h0);
    chk_word({28'h0, rd[9:6]}, 32'h8);
    chk_bit(rd[0], 1'b1);
    apb(1'b0, pmcs_pkg::OFF_FLAGS, 32'h0);
    chk_bit(rd[0], 1'b1);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge pclk);
    errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    turn_on_request = 1'b0;
    vin_above_input_undervoltage_threshold = 1'b0;
    card_rail_select = 1'b0;
    io_supply_ok = 1'b1;
    fault_in = 4'h0;
    void'($urandom(25));
    tick(5);
    presetn <= 1'b1;
    tick(1);
    rchk(pmcs_pkg::OFF_CTRL, 32'h0);
    rchk(pmcs_pkg::OFF_SEQ, {5'h00, pmcs_pkg::SEQ_RST});
    rchk(pmcs_pkg::OFF_PFM, 32'h0);
    rchk(pmcs_pkg::OFF_MASK, 32'h0);
    rchk(8'h1c, 32'h0);
    chk_bit(err, 1'b1);
    chk_bit(rst_n, 1'b0);
    chk_bit(osc_untrimmed_sel, 1'b1);
    for (int j = 0; j < 4; j++) begin
      card_rail_select <= j[0];
      io_supply_ok <= j[1];
      tick(6);
      chk_bit(card_low_range, j[0] | ~j[1]);
    end
    for (int k = 0; k < 2; k++) begin
      run_seq(k);
      if (k == 0) begin
        chk_bit(osc_untrimmed_sel, 1'b0);
        apb(1'b1, pmcs_pkg::OFF_PFM, 32'h1ff);
        tick(4);
        chk_bit(osc_untrimmed_sel, 1'b1);
        apb(1'b1, pmcs_pkg::OFF_PFM, 32'h0);
        np = 0;
        repeat (50) begin
          @(posedge pclk);
          if (sw_phase_pulse === 1'b1) np++;
        end
        chk_word(np, 32'd10);
        apb(1'b1, pmcs_pkg::OFF_FLAGS, 32'h3f);
        apb(1'b1, pmcs_pkg::OFF_MASK, 32'h04);
        fault_in <= 4'h1;
        tick(40);
        chk_bit(irq_n, 1'b1);
        fault_in <= 4'h0;
        apb(1'b1, pmcs_pkg::OFF_FLAGS, 32'h04);
        apb(1'b1, pmcs_pkg::OFF_MASK, 32'h0);
        fault_in <= 4'h2;
        tick(40);
        chk_bit(irq_n, 1'b0);
        fault_in <= 4'h0;
        tick(40);
        apb(1'b1, pmcs_pkg::OFF_FLAGS, 32'h0);
        chk_bit(irq_n, 1'b0);
        apb(1'b1, pmcs_pkg::OFF_FLAGS, 32'h08);
        tick(4);
        chk_bit(irq_n, 1'b1);
        turn_on_request <= 1'b0;
      end else begin
        vin_above_input_undervoltage_threshold <= 1'b0;
      end
      cyc = 0;
      while (rst_n !== 1'b0 && cyc < 200) begin
        @(posedge pclk);
        cyc++;
      end
      chk_bit(cyc < 200, 1'b1);
      chk_word({23'h0, reg_enable}, 32'h0);
      tick(40);
      chk_bit(rst_n, 1'b0);
    end
    chk_bit(osc_untrimmed_sel, 1'b1);
    give_verdict();
  end
endmodule
